// ==== core/uart_xf_pkg.sv ====
package uart_xf_pkg;
    // Register byte addresses on the plain register port
    localparam logic [7:0] OFS_EXTRA = 8'h00;
    localparam logic [7:0] OFS_STOP_CHAR = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    // Field positions in the extra features control register
    localparam int unsigned EF_IRDA = 7;
    localparam int unsigned EF_INVERT = 5;
    localparam int unsigned EF_TXDRIVE = 4;
    localparam int unsigned EF_TXHALT = 2;
    localparam int unsigned EF_RXHALT = 1;
    localparam int unsigned EF_MULTI = 0;
    // Field positions in the configuration register
    localparam int unsigned CF_MCR_RTS = 0;
    localparam int unsigned CF_SC_DETECT = 1;
    localparam int unsigned CF_LSI_EN = 2;
    localparam int unsigned CF_HW_FLOW = 3;
    localparam int unsigned CF_IRDA_EN = 4;
    // Field positions in the status register
    localparam int unsigned ST_RTS = 0;
    localparam int unsigned ST_RXHALT = 1;
    localparam int unsigned ST_DIR = 2;
    localparam int unsigned ST_TXSTOP = 3;
    // Reset values
    localparam logic [7:0] EXTRA_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] STOP_CHAR_RESET = 8'h00;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic RTS_INACTIVE = 1'b1;
    // Infrared pulse timing in 16x baud ticks
    localparam logic [3:0] IR_LAST_PHASE = 4'hf;
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    // Driver direction sequencer states
    typedef enum logic [1:0] {
        DIR_IDLE = 2'b00,
        DIR_WAIT = 2'b01,
        DIR_SEND = 2'b10
    } dir_state_t;
endpackage

// ==== core/irda_pulse_encoder.sv ====
`timescale 1ns/1ps
module irda_pulse_encoder import uart_xf_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial bit stream from the serializer
    input wire logic enable,
    input wire logic tick16,
    input wire logic bit_start,
    input wire logic tx_bit,
    // Infrared output, high while the emitter fires
    output logic ir_out
);
    // Encoder state
    typedef struct packed {
        logic [3:0] phase; // Tick position inside the bit
        logic bit_val; // Bit being encoded
        logic out; // Registered pulse
    } ir_state_t;

    ir_state_t st;
    ir_state_t next_st;

    assign ir_out = st.out;

    // A zero bit fires for the first three of sixteen ticks
    always_comb begin
        next_st = st;
        if (tick16) begin
            if (bit_start) begin
                next_st.phase = 4'h0;
                next_st.bit_val = tx_bit;
            end else if (st.phase != IR_LAST_PHASE) begin
                // Saturate so a stalled stream never re-fires
                next_st.phase = st.phase + 4'h1;
            end
        end
        next_st.out = enable & ~next_st.bit_val & (next_st.phase < IR_PULSE_TICKS); // RULE1
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{phase: IR_LAST_PHASE, bit_val: 1'b1, out: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    pulse_start_a: assert property (tick16 && bit_start && !tx_bit && enable |=> ir_out) // RULE1
        else $error("zero bit did not start an infrared pulse");
    pulse_end_a: assert property (tick16 && !bit_start && st.phase == IR_PULSE_TICKS - 4'h1
        |=> !ir_out) // RULE1
        else $error("infrared pulse longer than three ticks");
    ir_pulse_c: cover property (!ir_out ##1 ir_out ##[1:40] !ir_out);
endmodule

// ==== core/rs485_direction.sv ====
`timescale 1ns/1ps
module rs485_direction import uart_xf_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Transmit path activity
    input wire logic tx_fifo_write,
    input wire logic tx_fifo_empty,
    input wire logic tx_shift_busy,
    // High from a host write until the last bit has left
    output logic active
);
    // Sequencer state
    typedef struct packed {
        dir_state_t state;
        logic active;
    } dir_reg_t;

    dir_reg_t st;
    dir_reg_t next_st;

    assign active = st.active;

    // WAIT covers the gap before the shifter picks up the first character
    always_comb begin
        next_st = st;
        case (st.state)
            DIR_IDLE: begin
                if (tx_fifo_write) begin
                    next_st.state = DIR_WAIT; // RULE10
                end
            end
            DIR_WAIT: begin
                if (tx_shift_busy) begin
                    next_st.state = DIR_SEND;
                end
            end
            DIR_SEND: begin
                // Release only once nothing is queued and the shifter is idle
                if (!tx_shift_busy && tx_fifo_empty && !tx_fifo_write) begin
                    next_st.state = DIR_IDLE; // RULE10
                end
            end
            default: begin
                next_st.state = DIR_IDLE;
            end
        endcase
        next_st.active = (next_st.state != DIR_IDLE);
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{state: DIR_IDLE, active: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    dir_assert_a: assert property (st.state == DIR_IDLE && tx_fifo_write |=> active) // RULE10
        else $error("host write did not assert direction");
    dir_release_a: assert property (st.state == DIR_SEND && !tx_shift_busy && tx_fifo_empty
        && !tx_fifo_write |=> !active) // RULE10
        else $error("direction held after last bit");
    dir_hold_a: assert property (active && tx_shift_busy |=> active) // RULE10
        else $error("direction dropped during a character");
    dir_cycle_c: cover property (!active ##1 active ##[1:100] !active);
endmodule

// ==== core/uart_extra_features.sv ====
// Contract
// RULE1: Bit7 zero selects infrared 3/16 pulse encoding
// RULE2: Bit5 inverts direction pin levels
// RULE3: Bit4 lets transmitter drive request pin
// RULE4: Transmit halt stops serial output only
// RULE5: Character in shifter finishes before halting
// RULE6: Receive halt stops at once, flushes shifter
// RULE7: Software avoids receive halt mid character
// RULE8: Bit0 selects RS-232 or 9-bit multidrop
// RULE9: Request pin: modem bit or flow, overridden
// RULE10: Pin low on write, high after last bit
// RULE11: Software disables hardware flow before direction mode
// RULE12: Ninth bit one marks address, interrupts
// RULE13: Software disables all flow before multidrop
// RULE14: Software sets forced parity zero, detection off
// RULE15: Halted receiver drops data, keeps addresses
// RULE16: Controller enables receiver only on own address
// RULE17: Enabled receiver flags next address byte
// RULE18: Auto mode discards data and foreign addresses
// RULE19: Matching address enables receiver, stored, interrupts
// RULE20: Later foreign address disables receiver, ignored
// RULE21: Reserved bits 6 and 3 read zero
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module uart_extra_features import uart_xf_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Transmit path
    input wire logic tx_fifo_write,
    input wire logic tx_fifo_empty,
    input wire logic tx_shift_busy,
    input wire logic tx_serial,
    output logic tx_load_allow,
    output logic tx_line,
    // Infrared encoder timing
    input wire logic ir_tick16,
    input wire logic ir_bit_start,
    output logic ir_tx,
    // Request to send pin
    input wire logic flow_rts_n,
    output logic rts_n,
    // Receive path
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_char_ninth,
    input wire logic rx_parity_err,
    output logic rx_flush,
    output logic rx_push,
    output logic [7:0] rx_push_data,
    output logic rx_push_perr,
    output logic line_status_irq
);
    // All block state
    typedef struct packed {
        logic irda_sel; // Pulse ratio select
        logic direction_polarity_invert; // Swap direction levels
        logic transmitter_drives_direction; // Transmitter owns request pin
        logic transmit_halt; // Software asked transmitter to stop
        logic receive_halt; // Receiver closed, software or hardware
        logic multidrop; // 9-bit line mode
        logic [7:0] second_stop_character; // Station address for auto match
        logic mcr_rts; // Modem control request bit
        logic sc_detect; // Special character detection
        logic lsi_enable; // Line status interrupt enable
        logic hw_flow; // Hardware flow control owns pin
        logic irda_enable; // Infrared output in use
        logic [7:0] rdata; // Read answer
        logic flush; // Shifter dump request
        logic flush_win; // Cycle that accepts the dumped character
        logic push; // Receive FIFO write
        logic [7:0] push_data; // Character to store
        logic push_perr; // Parity error position
        logic lsi_irq; // Line status interrupt pulse
        logic tx_stopped; // Transmitter in disabled state
        logic load_allow; // Serializer may load a character
        logic line; // Transmit pin
        logic rts_n; // Request pin level
    } xf_state_t;

    xf_state_t st;
    xf_state_t next_st;
    logic dir_active; // Transmitter has data on the line
    logic rx_open; // Receiver accepts characters now
    logic is_addr; // Current character is an address
    logic addr_match; // Address equals programmed station

    // Outputs come straight from the state register
    assign reg_rdata = st.rdata;
    assign tx_load_allow = st.load_allow;
    assign tx_line = st.line;
    assign rts_n = st.rts_n;
    assign rx_flush = st.flush;
    assign rx_push = st.push;
    assign rx_push_data = st.push_data;
    assign rx_push_perr = st.push_perr;
    assign line_status_irq = st.lsi_irq;

    // Direction sequencer for the automatic driver control
    rs485_direction u_dir (
        .clk(clk),
        .rst(rst),
        .tx_fifo_write(tx_fifo_write),
        .tx_fifo_empty(tx_fifo_empty),
        .tx_shift_busy(tx_shift_busy),
        .active(dir_active)
    );

    // Infrared encoder, 3/16 pulse only when the select bit is clear
    irda_pulse_encoder u_ir (
        .clk(clk),
        .rst(rst),
        .enable(st.irda_enable & ~st.irda_sel), // RULE1
        .tick16(ir_tick16),
        .bit_start(ir_bit_start),
        .tx_bit(tx_serial),
        .ir_out(ir_tx)
    );

    // Character classification
    assign rx_open = ~st.receive_halt | st.flush_win;
    assign is_addr = st.multidrop & rx_char_ninth; // RULE12
    assign addr_match = (rx_char_data == st.second_stop_character);

    // Next state: register access, receive filter, transmit halt, pins
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        next_st.flush = 1'b0;
        next_st.push = 1'b0;
        next_st.lsi_irq = 1'b0;
        next_st.flush_win = st.flush;
        // Reads; unmapped addresses answer zero
        if (reg_rd) begin
            case (reg_addr)
                OFS_EXTRA: begin
                    next_st.rdata[EF_IRDA] = st.irda_sel;
                    next_st.rdata[EF_INVERT] = st.direction_polarity_invert;
                    next_st.rdata[EF_TXDRIVE] = st.transmitter_drives_direction;
                    next_st.rdata[EF_TXHALT] = st.transmit_halt;
                    next_st.rdata[EF_RXHALT] = st.receive_halt;
                    next_st.rdata[EF_MULTI] = st.multidrop; // RULE21
                end
                OFS_STOP_CHAR: begin
                    next_st.rdata = st.second_stop_character;
                end
                OFS_CONFIG: begin
                    next_st.rdata[CF_MCR_RTS] = st.mcr_rts;
                    next_st.rdata[CF_SC_DETECT] = st.sc_detect;
                    next_st.rdata[CF_LSI_EN] = st.lsi_enable;
                    next_st.rdata[CF_HW_FLOW] = st.hw_flow;
                    next_st.rdata[CF_IRDA_EN] = st.irda_enable;
                end
                OFS_STATUS: begin
                    next_st.rdata[ST_RTS] = st.rts_n;
                    next_st.rdata[ST_RXHALT] = st.receive_halt;
                    next_st.rdata[ST_DIR] = dir_active;
                    next_st.rdata[ST_TXSTOP] = st.tx_stopped;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
        // Writes; reserved bits are simply not stored
        if (reg_wr) begin
            case (reg_addr)
                OFS_EXTRA: begin
                    next_st.irda_sel = reg_wdata[EF_IRDA];
                    next_st.direction_polarity_invert = reg_wdata[EF_INVERT];
                    next_st.transmitter_drives_direction = reg_wdata[EF_TXDRIVE];
                    next_st.transmit_halt = reg_wdata[EF_TXHALT];
                    next_st.receive_halt = reg_wdata[EF_RXHALT];
                    next_st.multidrop = reg_wdata[EF_MULTI]; // RULE8
                    // Closing the receiver dumps a partial character
                    next_st.flush = reg_wdata[EF_RXHALT] & ~st.receive_halt; // RULE6
                end
                OFS_STOP_CHAR: begin
                    next_st.second_stop_character = reg_wdata;
                end
                OFS_CONFIG: begin
                    next_st.mcr_rts = reg_wdata[CF_MCR_RTS];
                    next_st.sc_detect = reg_wdata[CF_SC_DETECT];
                    next_st.lsi_enable = reg_wdata[CF_LSI_EN];
                    next_st.hw_flow = reg_wdata[CF_HW_FLOW];
                    next_st.irda_enable = reg_wdata[CF_IRDA_EN];
                end
                default: begin
                end
            endcase
        end
        // Receive filter; hardware updates follow writes so they win
        next_st.push_data = rx_char_data;
        if (rx_char_valid) begin
            if (st.multidrop && st.sc_detect) begin
                if (is_addr && addr_match) begin
                    // Own address reopens the receiver
                    next_st.receive_halt = 1'b0; // RULE19
                    next_st.push = 1'b1; // RULE19
                    next_st.push_perr = rx_char_ninth;
                    next_st.lsi_irq = st.lsi_enable; // RULE12
                end else if (is_addr) begin
                    // Foreign address closes it and is thrown away
                    next_st.receive_halt = 1'b1; // RULE20
                end else begin
                    next_st.push = rx_open; // RULE18
                    next_st.push_perr = 1'b0;
                end
            end else if (st.multidrop) begin
                // Forced parity zero flags every address byte
                next_st.push = is_addr | rx_open; // RULE15
                next_st.push_perr = rx_char_ninth; // RULE17
                next_st.lsi_irq = is_addr & st.lsi_enable; // RULE12
            end else begin
                next_st.push = rx_open; // RULE8
                next_st.push_perr = rx_parity_err;
            end
        end
        // No new load once halt is asked; the running character completes
        next_st.load_allow = ~next_st.transmit_halt; // RULE4
        next_st.tx_stopped = next_st.transmit_halt
            & (st.tx_stopped | (~tx_shift_busy & ~st.load_allow)); // RULE5
        // A stopped transmitter holds the line at mark
        next_st.line = next_st.tx_stopped | tx_serial; // RULE4
        // Request pin source; the transmitter overrides both others
        if (st.transmitter_drives_direction) begin
            next_st.rts_n = st.direction_polarity_invert ? dir_active : ~dir_active; // RULE2
        end else if (st.hw_flow) begin
            next_st.rts_n = flow_rts_n; // RULE9
        end else begin
            next_st.rts_n = ~st.mcr_rts; // RULE9
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{irda_sel: EXTRA_RESET[EF_IRDA], multidrop: EXTRA_RESET[EF_MULTI],
                second_stop_character: STOP_CHAR_RESET, lsi_enable: CONFIG_RESET[CF_LSI_EN],
                load_allow: 1'b1, line: LINE_IDLE, rts_n: RTS_INACTIVE, default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    rts_modem_a: assert property (!st.transmitter_drives_direction && !st.hw_flow
        |=> rts_n == !$past(st.mcr_rts)) // RULE9
        else $error("request pin does not follow modem bit");
    rts_direct_a: assert property (st.transmitter_drives_direction
        && !st.direction_polarity_invert |=> rts_n == !$past(dir_active)) // RULE10
        else $error("direction pin wrong without inversion");
    rts_invert_a: assert property (st.transmitter_drives_direction
        && st.direction_polarity_invert |=> rts_n == $past(dir_active)) // RULE2
        else $error("direction pin wrong with inversion");
    tx_finish_a: assert property (!st.tx_stopped && tx_shift_busy |=> !st.tx_stopped) // RULE5
        else $error("transmitter stopped inside a character");
    tx_mute_a: assert property (st.tx_stopped |-> tx_line && !tx_load_allow) // RULE4
        else $error("stopped transmitter drives the line");
    rx_flush_a: assert property (reg_wr && reg_addr == OFS_EXTRA && reg_wdata[EF_RXHALT]
        && !st.receive_halt |=> rx_flush ##1 !rx_flush) // RULE6
        else $error("receive halt did not flush once");
    md_drop_a: assert property (rx_char_valid && st.multidrop && !st.sc_detect
        && !rx_char_ninth && st.receive_halt && !st.flush_win |=> !rx_push) // RULE15
        else $error("halted receiver stored a data byte");
    md_addr_a: assert property (rx_char_valid && st.multidrop && !st.sc_detect && rx_char_ninth
        |=> rx_push && rx_push_perr && line_status_irq == $past(st.lsi_enable)) // RULE17
        else $error("address byte not flagged");
    auto_match_a: assert property (rx_char_valid && st.multidrop && st.sc_detect
        && rx_char_ninth && addr_match |=> rx_push && rx_push_perr && !st.receive_halt) // RULE19
        else $error("matching address not taken");
    auto_reject_a: assert property (rx_char_valid && st.multidrop && st.sc_detect
        && rx_char_ninth && !addr_match |=> !rx_push && st.receive_halt) // RULE20
        else $error("foreign address not rejected");
    plain_rx_a: assert property (rx_char_valid && !st.multidrop && !st.receive_halt
        |=> rx_push && rx_push_perr == $past(rx_parity_err)) // RULE8
        else $error("plain mode character lost");
    reserved_zero_a: assert property (reg_rd && reg_addr == OFS_EXTRA
        |=> reg_rdata[6] == 1'b0 && reg_rdata[3] == 1'b0) // RULE21
        else $error("reserved bits read nonzero");

    auto_cycle_c: cover property (st.receive_halt ##1 !st.receive_halt ##[1:200] st.receive_halt);
    md_irq_c: cover property (line_status_irq && rx_push_perr);
    tx_stop_c: cover property (tx_shift_busy && st.transmit_halt ##[1:200] st.tx_stopped);
endmodule

// ==== testbench/rs485_station_model.sv ====
`timescale 1ns/1ps
module rs485_station_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Character to present, from the bench
    input wire logic send,
    input wire logic [7:0] send_data,
    input wire logic send_ninth,
    input wire logic send_perr,
    // Deserializer side
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic rx_char_ninth,
    output logic rx_parity_err,
    // Serializer side
    input wire logic tx_fifo_write,
    input wire logic tx_load_allow,
    output logic tx_fifo_empty,
    output logic tx_shift_busy,
    output logic tx_serial
);
    logic [6:0] depth; // Characters waiting to be sent
    logic [3:0] bits; // Bit times left in the shifter
    logic load; // Shifter takes the next character
    assign load = (bits == 4'h0) && tx_load_allow && (depth != 7'h00);
    assign tx_fifo_empty = (depth == 7'h00);
    assign tx_shift_busy = (bits != 4'h0);
    // Idle line sits high; a busy shifter shows a changing pattern
    assign tx_serial = tx_shift_busy ? bits[1] : 1'b1;
    // Shifter and FIFO depth
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            depth <= 7'h00;
            bits <= 4'h0;
        end else begin
            depth <= depth + {6'h00, tx_fifo_write} - {6'h00, load};
            if (load) begin
                bits <= 4'hf;
            end else if (bits != 4'h0) begin
                bits <= bits - 4'h1;
            end
        end
    end
    // Character lines change every cycle outside a valid pulse
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_char_valid <= 1'b0;
            rx_char_data <= 8'h00;
            rx_char_ninth <= 1'b0;
            rx_parity_err <= 1'b0;
        end else begin
            rx_char_valid <= send;
            rx_char_data <= send ? send_data : ~rx_char_data;
            rx_char_ninth <= send ? send_ninth : ~rx_char_ninth;
            rx_parity_err <= send ? send_perr : ~rx_parity_err;
        end
    end
endmodule

// ==== testbench/tb_uart_rs485_extra_features.sv ====
`timescale 1ns/1ps
module tb_uart_rs485_extra_features import uart_xf_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx_fifo_write = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rx_char_data, rx_push_data;
    logic ir_tick16 = 1'b0, flow_rts_n = 1'b1, send = 1'b0, s_ninth = 1'b0, s_perr = 1'b0;
    logic [7:0] s_data = 8'h00, a, d; // Station address and data byte
    logic tx_fifo_empty, tx_shift_busy, tx_serial, tx_load_allow, tx_line, ir_tx, rts_n;
    logic rx_char_valid, rx_char_ninth, rx_parity_err, rx_flush, rx_push, rx_push_perr;
    logic line_status_irq, rd_pend = 1'b0, seen_ir = 1'b0;
    logic [7:0] rd_q[$]; // Expected read answers
    logic [9:0] rx_q[$]; // Expected pushes: irq, perr, data
    logic [9:0] rx_e;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    // Block and far-side station
    // Bit starts on half the ticks, so a pulse also runs out between starts
    uart_extra_features uut (.*, .ir_bit_start(ir_tick16 & cyc[3]));
    rs485_station_model station (.*, .send_data(s_data), .send_ninth(s_ninth), .send_perr(s_perr));
    task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_byte(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Register writes and reads, one cycle strobes
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // One character from the line; a push is noted only where one is due
    task automatic rx(input logic [7:0] dt, input logic nin, input logic pe, input logic due,
                      input logic e_perr, input logic e_irq);
        @(posedge clk);
        send <= 1'b1;
        s_data <= dt;
        s_ninth <= nin;
        s_perr <= pe;
        if (due) rx_q.push_back({e_irq, e_perr, dt});
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic host_tx;
        @(posedge clk);
        tx_fifo_write <= 1'b1;
        @(posedge clk);
        tx_fifo_write <= 1'b0;
    endtask
    // Bounded wait for the request pin, then compare
    task automatic wait_rts(input logic e, input int lim);
        int k = 0;
        while (rts_n !== e && k < lim) begin
            @(posedge clk);
            k++;
        end
        cmp_bit("rts_n", e, rts_n);
    endtask
    // Watcher: read answers stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_pend <= reg_rd;
        if (rd_pend && rd_q.size() > 0) cmp_byte("reg_rdata", rd_q.pop_front(), reg_rdata);
        if (rx_push && rx_q.size() == 0) cmp_bit("rx_push", 1'b0, rx_push);
        if (rx_push && rx_q.size() > 0) begin
            rx_e = rx_q.pop_front();
            cmp_byte("rx_push_data", rx_e[7:0], rx_push_data);
            cmp_bit("rx_push_perr", rx_e[8], rx_push_perr);
            cmp_bit("line_status_irq", rx_e[9], line_status_irq);
        end
    end
    // Infrared bit timing, plus sticky note of any pulse; run ceiling
    always @(posedge clk) begin
        ir_tick16 <= ~ir_tick16;
        if (ir_tx === 1'b1) seen_ir <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'hf2a1));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_EXTRA, EXTRA_RESET);
        rd(OFS_STATUS, 8'h01);
        rd(8'h10, 8'h00);
        d = 8'($urandom) | 8'h48;
        wr(OFS_EXTRA, d);
        rd(OFS_EXTRA, d & 8'hb7);
        wr(OFS_EXTRA, 8'h00);
        wr(OFS_CONFIG, 8'h01);
        wait_rts(1'b0, 5);
        wr(OFS_CONFIG, 8'h09);
        wait_rts(1'b1, 5);
        wr(OFS_CONFIG, 8'h01);
        wr(OFS_EXTRA, 8'h10);
        wait_rts(1'b1, 5);
        host_tx();
        wait_rts(1'b0, 4);
        wait_rts(1'b1, 40);
        cmp_bit("tx_shift_busy", 1'b0, tx_shift_busy);
        cmp_bit("seen_ir", 1'b0, seen_ir);
        wr(OFS_CONFIG, 8'h11);
        wr(OFS_EXTRA, 8'h30);
        wait_rts(1'b0, 5);
        host_tx();
        wait_rts(1'b1, 4);
        wait_rts(1'b0, 40);
        cmp_bit("seen_ir", 1'b1, seen_ir);
        wr(OFS_EXTRA, 8'h00);
        host_tx();
        repeat (2) @(posedge clk);
        wr(OFS_EXTRA, 8'h04);
        @(posedge clk);
        #1 cmp_bit("tx_load_allow", 1'b0, tx_load_allow);
        cmp_bit("tx_shift_busy", 1'b1, tx_shift_busy);
        host_tx();
        repeat (25) @(posedge clk);
        cmp_bit("tx_shift_busy", 1'b0, tx_shift_busy);
        cmp_bit("tx_line", 1'b1, tx_line);
        rd(OFS_STATUS, 8'h0c);
        wr(OFS_CONFIG, 8'h00);
        wr(OFS_EXTRA, 8'h02);
        #1 cmp_bit("rx_flush", 1'b1, rx_flush);
        rx(8'($urandom), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(OFS_EXTRA, 8'h00);
        rx(8'($urandom), 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        wr(OFS_CONFIG, 8'h04);
        wr(OFS_EXTRA, 8'h03);
        rx(8'($urandom), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rx(8'($urandom), 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        wr(OFS_EXTRA, 8'h01);
        rx(8'($urandom), 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        rx(8'($urandom), 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        a = 8'($urandom);
        wr(OFS_STOP_CHAR, a);
        wr(OFS_CONFIG, 8'h06);
        wr(OFS_EXTRA, 8'h03);
        rx(a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rx(a ^ 8'h5a, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rx(a, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        rx(a ^ 8'h01, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        rd(OFS_STATUS, 8'h01);
        rx(a ^ 8'h80, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(OFS_STATUS, 8'h03);
        rx(a, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        repeat (4) @(posedge clk);
        cmp_byte("pending", 8'h00, 8'(rx_q.size() + rd_q.size()));
        wrap_up();
    end
endmodule
